// >>> logic/bit_shift_flag_instr_exec.sv
`timescale 1ns/1ns
`include "bit_exec_consts.svh"
`default_nettype none

module bit_shift_flag_instr_exec #(
  parameter int REG_COUNT = 32
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // instruction issue
  input  wire logic       instrValid,
  input  wire logic [4:0] instrOp,
  input  wire logic [4:0] regAddr,
  input  wire logic [2:0] bitSel,
  input  wire logic [4:0] ioAddrIn,
  input  wire logic [7:0] immData,
  output logic            instrReady,
  output logic            instrDone,
  // stack port
  output logic            stackPush,
  output logic      [7:0] stackPushData,
  output logic            stackPop,
  input  wire logic [7:0] stackPopData,
  // io register port
  output logic            ioRead,
  output logic            ioWrite,
  output logic      [4:0] ioAddr,
  input  wire logic [7:0] ioReadData,
  output logic      [7:0] ioWriteData,
  // debug
  output logic            breakHalt,
  input  wire logic       debugResume,
  // status and writeback view
  output logic      [7:0] statusFlags,
  output logic            regWbValid,
  output logic      [4:0] regWbAddr,
  output logic      [7:0] regWbData
);

  generate
    if (REG_COUNT != 32) begin : g_bad_count
      $error("bit_shift_flag_instr_exec: five-bit register address needs 32 registers");
    end
  endgenerate

  // ----------------------------------------
  // state
  // ----------------------------------------
  bit_exec_pkg::exec_state_t s_reg;
  bit_exec_pkg::exec_state_t s_next;

  bit_exec_pkg::op_t opIn;
  logic              twoCycle;
  logic              issue;
  logic              rfWe;
  logic [4:0]        rfWaddr;
  logic [7:0]        rfWdata;
  logic [4:0]        rfRaddr;
  logic [7:0]        rfRdData;
  logic [7:0]        shiftRes;
  logic              shiftCarry;

  assign opIn = bit_exec_pkg::op_t'(instrOp);

  assign twoCycle = (s_reg.op == bit_exec_pkg::push_op) || (s_reg.op == bit_exec_pkg::pop_op) ||
                    (s_reg.op == bit_exec_pkg::io_bit_set_op) || (s_reg.op == bit_exec_pkg::io_bit_clear_op);

  // ----------------------------------------
  // handshake
  // ----------------------------------------
  // a one-cycle op frees the slot in its own exec cycle, so short ops stream
  assign instrReady = (s_reg.seq == bit_exec_pkg::SEQ_IDLE) ||
                      (s_reg.seq == bit_exec_pkg::SEQ_EXEC && !twoCycle && s_reg.op != bit_exec_pkg::break_op);
  assign issue      = instrValid && instrReady;
  assign instrDone  = (s_reg.seq == bit_exec_pkg::SEQ_SECOND) ||
                      (s_reg.seq == bit_exec_pkg::SEQ_HALT && debugResume) ||
                      (s_reg.seq == bit_exec_pkg::SEQ_EXEC && !twoCycle && s_reg.op != bit_exec_pkg::break_op);

  assign stackPush = (s_reg.seq == bit_exec_pkg::SEQ_SECOND) && (s_reg.op == bit_exec_pkg::push_op);
  assign stackPop  = (s_reg.seq == bit_exec_pkg::SEQ_EXEC) && (s_reg.op == bit_exec_pkg::pop_op);
  assign ioRead    = (s_reg.seq == bit_exec_pkg::SEQ_EXEC) &&
                     (s_reg.op == bit_exec_pkg::io_bit_set_op || s_reg.op == bit_exec_pkg::io_bit_clear_op);
  assign ioWrite   = (s_reg.seq == bit_exec_pkg::SEQ_SECOND) &&
                     (s_reg.op == bit_exec_pkg::io_bit_set_op || s_reg.op == bit_exec_pkg::io_bit_clear_op);
  assign breakHalt = (s_reg.seq == bit_exec_pkg::SEQ_HALT);

  assign stackPushData = s_reg.stackPushData;
  assign ioWriteData   = s_reg.ioWriteData;
  assign ioAddr        = s_reg.ioAddr;
  assign statusFlags   = s_reg.flags;
  assign regWbValid    = s_reg.wbValid;
  assign regWbAddr     = s_reg.wbAddr;
  assign regWbData     = s_reg.wbData;

  // read address follows the issuing op, else holds the current one
  assign rfRaddr = issue ? regAddr : s_reg.regAddr;

  // ----------------------------------------
  // datapath helpers
  // ----------------------------------------
  reg_file_mem #(
    .WIDTH (8),
    .DEPTH (REG_COUNT)
  ) u_regs (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .we        (rfWe),
    .waddr     (rfWaddr),
    .wdata     (rfWdata),
    .raddr     (rfRaddr),
    .rdata_reg (rfRdData)
  );

  shift_rotate_unit u_shift (
    .op       (s_reg.op),
    .operand  (rfRdData),
    .carryIn  (s_reg.flags[`FLAG_CARRY]),
    .result   (shiftRes),
    .carryOut (shiftCarry)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next         = s_reg;
    s_next.wbValid = 1'b0;
    rfWe           = 1'b0;
    rfWaddr        = s_reg.regAddr;
    rfWdata        = rfRdData;
    unique case (s_reg.seq)
      bit_exec_pkg::SEQ_IDLE: begin
      end
      bit_exec_pkg::SEQ_EXEC: begin
        unique case (s_reg.op)
          bit_exec_pkg::push_op: begin
            s_next.stackPushData = rfRdData;
            s_next.seq           = bit_exec_pkg::SEQ_SECOND;
          end
          bit_exec_pkg::pop_op: begin
            s_next.seq = bit_exec_pkg::SEQ_SECOND;
          end
          bit_exec_pkg::io_bit_set_op, bit_exec_pkg::io_bit_clear_op: begin
            s_next.ioWriteData = ioReadData;
            s_next.ioWriteData[s_reg.bitSel] = (s_reg.op == bit_exec_pkg::io_bit_set_op);
            s_next.seq         = bit_exec_pkg::SEQ_SECOND;
          end
          bit_exec_pkg::logic_shift_left_op, bit_exec_pkg::logic_shift_right_op,
          bit_exec_pkg::rotate_left_carry_op, bit_exec_pkg::rotate_right_carry_op,
          bit_exec_pkg::arith_shift_right_op: begin
            rfWe    = 1'b1;
            rfWdata = shiftRes;
            s_next.flags[`FLAG_CARRY] = shiftCarry;
            s_next.flags[`FLAG_ZERO]  = (shiftRes == 8'h00);
            s_next.flags[`FLAG_NEG]   = shiftRes[7];
            s_next.flags[`FLAG_OVF]   = shiftRes[7] ^ shiftCarry;
            // sign follows N xor V, which here reduces to the new carry
            s_next.flags[`FLAG_SIGN]  = shiftCarry;
          end
          bit_exec_pkg::nibble_swap_op: begin
            rfWe    = 1'b1;
            rfWdata = {rfRdData[3:0], rfRdData[7:4]};
          end
          bit_exec_pkg::bit_to_transfer_flag_op: begin
            s_next.flags[`FLAG_XFER] = rfRdData[s_reg.bitSel];
          end
          bit_exec_pkg::transfer_flag_to_bit_op: begin
            rfWe = 1'b1;
            rfWdata[s_reg.bitSel] = s_reg.flags[`FLAG_XFER];
          end
          bit_exec_pkg::overflow_flag_set_op: begin
            s_next.flags[`FLAG_OVF] = 1'b1;
          end
          bit_exec_pkg::overflow_flag_clear_op: begin
            s_next.flags[`FLAG_OVF] = 1'b0;
          end
          bit_exec_pkg::half_carry_set_op: begin
            s_next.flags[`FLAG_HALF] = 1'b1;
          end
          bit_exec_pkg::half_carry_clear_op: begin
            s_next.flags[`FLAG_HALF] = 1'b0;
          end
          bit_exec_pkg::flag_set_op: begin
            s_next.flags[s_reg.bitSel] = 1'b1;
          end
          bit_exec_pkg::flag_clear_op: begin
            s_next.flags[s_reg.bitSel] = 1'b0;
          end
          bit_exec_pkg::break_op: begin
            s_next.seq = bit_exec_pkg::SEQ_HALT;
          end
          bit_exec_pkg::reg_load_op: begin
            rfWe    = 1'b1;
            rfWdata = s_reg.imm;
          end
          default: begin
            // nop and unassigned codes: slot consumed, nothing written
          end
        endcase
        if (!twoCycle && s_reg.op != bit_exec_pkg::break_op) begin
          s_next.seq = bit_exec_pkg::SEQ_IDLE;
        end
      end
      bit_exec_pkg::SEQ_SECOND: begin
        if (s_reg.op == bit_exec_pkg::pop_op) begin
          rfWe    = 1'b1;
          rfWdata = stackPopData;
        end
        s_next.seq = bit_exec_pkg::SEQ_IDLE;
      end
      bit_exec_pkg::SEQ_HALT: begin
        if (debugResume) begin
          s_next.seq = bit_exec_pkg::SEQ_IDLE;
        end
      end
    endcase
    if (rfWe) begin
      s_next.wbValid = 1'b1;
      s_next.wbAddr  = rfWaddr;
      s_next.wbData  = rfWdata;
    end
    if (issue) begin
      s_next.seq     = bit_exec_pkg::SEQ_EXEC;
      s_next.op      = opIn;
      s_next.regAddr = regAddr;
      s_next.bitSel  = bitSel;
      s_next.imm     = immData;
      s_next.ioAddr  = ioAddrIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_reg               <= '0;
      s_reg.seq           <= bit_exec_pkg::SEQ_IDLE;
      s_reg.op            <= bit_exec_pkg::nop_op;
      s_reg.flags         <= `FLAGS_RESET;
      s_reg.stackPushData <= `DATA_RESET;
      s_reg.ioWriteData   <= `DATA_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic inExec;
  assign inExec = (s_reg.seq == bit_exec_pkg::SEQ_EXEC);

  a_push_two_cyc: assert property (inExec && s_reg.op == bit_exec_pkg::push_op |->
    !stackPush ##1 (stackPush && stackPushData == $past(rfRdData) && $stable(statusFlags)))
    else $error("push timing or data wrong");
  a_pop_load: assert property (stackPop |=> ##1 (regWbValid && regWbData == $past(stackPopData) &&
    $stable(statusFlags))) else $error("pop did not load register");
  a_io_bit_force: assert property (ioRead |=> ioWrite && ioWriteData[s_reg.bitSel] ==
    (s_reg.op == bit_exec_pkg::io_bit_set_op) && $stable(statusFlags)) else $error("io bit not forced");
  a_lsl_result: assert property (inExec && s_reg.op == bit_exec_pkg::logic_shift_left_op |=>
    regWbData == {$past(rfRdData[6:0]), 1'b0} && statusFlags[`FLAG_CARRY] == $past(rfRdData[7]))
    else $error("left shift result wrong");
  a_lsr_result: assert property (inExec && s_reg.op == bit_exec_pkg::logic_shift_right_op |=>
    regWbData == {1'b0, $past(rfRdData[7:1])} && !statusFlags[`FLAG_NEG]) else $error("right shift wrong");
  a_rol_carry: assert property (inExec && s_reg.op == bit_exec_pkg::rotate_left_carry_op |=>
    regWbData[0] == $past(s_reg.flags[`FLAG_CARRY]) && statusFlags[`FLAG_CARRY] == $past(rfRdData[7]))
    else $error("rotate left wrong");
  a_ror_carry: assert property (inExec && s_reg.op == bit_exec_pkg::rotate_right_carry_op |=>
    regWbData[7] == $past(s_reg.flags[`FLAG_CARRY]) && statusFlags[`FLAG_CARRY] == $past(rfRdData[0]))
    else $error("rotate right wrong");
  a_asr_sign_keep: assert property (inExec && s_reg.op == bit_exec_pkg::arith_shift_right_op |=>
    regWbData == {$past(rfRdData[7]), $past(rfRdData[7:1])} && statusFlags[`FLAG_ZERO] == (regWbData == 8'h00))
    else $error("arithmetic shift wrong");
  a_bst_only_t: assert property (inExec && s_reg.op == bit_exec_pkg::bit_to_transfer_flag_op |=>
    statusFlags[`FLAG_XFER] == $past(rfRdData[s_reg.bitSel]) && !regWbValid) else $error("bit store wrong");
  a_bld_bit: assert property (inExec && s_reg.op == bit_exec_pkg::transfer_flag_to_bit_op |=>
    regWbData[$past(s_reg.bitSel)] == statusFlags[`FLAG_XFER] && $stable(statusFlags)) else $error("bit load wrong");
  a_ovf_ops: assert property (inExec && s_reg.op == bit_exec_pkg::overflow_flag_set_op |=>
    statusFlags == ($past(statusFlags) | 8'h08)) else $error("overflow set wrong");
  a_half_ops: assert property (inExec && s_reg.op == bit_exec_pkg::half_carry_clear_op |=>
    statusFlags == ($past(statusFlags) & 8'hdf)) else $error("half carry clear wrong");
  a_break_halts: assert property (inExec && s_reg.op == bit_exec_pkg::break_op |=>
    breakHalt && !instrReady) else $error("break did not halt");
  a_swap_nibbles: assert property (inExec && s_reg.op == bit_exec_pkg::nibble_swap_op |=>
    regWbData == {$past(rfRdData[3:0]), $past(rfRdData[7:4])} && $stable(statusFlags)) else $error("swap wrong");
  a_nop_quiet: assert property (inExec && s_reg.op == bit_exec_pkg::nop_op |-> instrDone ##1
    (!regWbValid && $stable(statusFlags))) else $error("nop changed state");

  c_push_seen:  cover property (stackPush);
  c_back2back:  cover property (instrDone && issue ##1 instrDone);
  c_break_exit: cover property (breakHalt ##1 !breakHalt);

endmodule // bit_shift_flag_instr_exec

`default_nettype wire

// >>> logic/bit_exec_consts.svh
`ifndef BIT_EXEC_CONSTS_SVH
`define BIT_EXEC_CONSTS_SVH

// ----------------------------------------
// status flag positions
// ----------------------------------------
`define FLAG_CARRY      3'h0
`define FLAG_ZERO       3'h1
`define FLAG_NEG        3'h2
`define FLAG_OVF        3'h3
`define FLAG_SIGN       3'h4
`define FLAG_HALF       3'h5
`define FLAG_XFER       3'h6
`define FLAG_IRQ        3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define FLAGS_RESET     8'h00
`define DATA_RESET      8'h00

// ----------------------------------------
// cycle counts, issue to done
// ----------------------------------------
`define CYCLES_SHORT    2'h1
`define CYCLES_LONG     2'h2

`endif

// >>> logic/bit_exec_pkg.sv
package bit_exec_pkg;

  // ----------------------------------------
  // operation codes on the instruction port
  // ----------------------------------------
  typedef enum logic [4:0] {
    nop_op                   = 5'h00,
    push_op                  = 5'h01,
    pop_op                   = 5'h02,
    io_bit_set_op            = 5'h03,
    io_bit_clear_op          = 5'h04,
    logic_shift_left_op      = 5'h05,
    logic_shift_right_op     = 5'h06,
    rotate_left_carry_op     = 5'h07,
    rotate_right_carry_op    = 5'h08,
    arith_shift_right_op     = 5'h09,
    nibble_swap_op           = 5'h0a,
    bit_to_transfer_flag_op  = 5'h0b,
    transfer_flag_to_bit_op  = 5'h0c,
    overflow_flag_set_op     = 5'h0d,
    overflow_flag_clear_op   = 5'h0e,
    half_carry_set_op        = 5'h0f,
    half_carry_clear_op      = 5'h10,
    flag_set_op              = 5'h11,
    flag_clear_op            = 5'h12,
    break_op                 = 5'h13,
    reg_load_op              = 5'h14
  } op_t;

  // ----------------------------------------
  // execution sequencer, gray along idle-exec-second
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_EXEC   = 2'b01,
    SEQ_SECOND = 2'b11,
    SEQ_HALT   = 2'b10
  } seq_t;

  typedef struct packed {
    seq_t       seq;
    op_t        op;
    logic [4:0] regAddr;
    logic [2:0] bitSel;
    logic [7:0] imm;
    logic [4:0] ioAddr;
    logic [7:0] flags;
    logic [7:0] stackPushData;
    logic [7:0] ioWriteData;
    logic       wbValid;
    logic [4:0] wbAddr;
    logic [7:0] wbData;
  } exec_state_t;

endpackage

// >>> logic/reg_file_mem.sv
`timescale 1ns/1ns
`default_nettype none

module reg_file_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // registered read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_reg
);

  generate
    if (DEPTH < 2 || (1 << AW) < DEPTH || WIDTH < 1) begin : g_bad
      $error("reg_file_mem: unsupported geometry");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // write-first bypass so back-to-back ops on one register see fresh data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (we && waddr == raddr) begin
      rdata_reg <= wdata;
    end else begin
      rdata_reg <= mem[raddr];
    end
  end

endmodule // reg_file_mem

`default_nettype wire

// >>> logic/shift_rotate_unit.sv
`timescale 1ns/1ns
`default_nettype none

module shift_rotate_unit (
  // operation
  input  wire bit_exec_pkg::op_t op,
  input  wire logic [7:0]        operand,
  input  wire logic              carryIn,
  // result
  output logic      [7:0]        result,
  output logic                   carryOut
);

  always_comb begin
    result   = operand;
    carryOut = carryIn;
    unique case (op)
      bit_exec_pkg::logic_shift_left_op: begin
        result   = {operand[6:0], 1'b0};
        carryOut = operand[7];
      end
      bit_exec_pkg::logic_shift_right_op: begin
        result   = {1'b0, operand[7:1]};
        carryOut = operand[0];
      end
      bit_exec_pkg::rotate_left_carry_op: begin
        result   = {operand[6:0], carryIn};
        carryOut = operand[7];
      end
      bit_exec_pkg::rotate_right_carry_op: begin
        result   = {carryIn, operand[7:1]};
        carryOut = operand[0];
      end
      bit_exec_pkg::arith_shift_right_op: begin
        result   = {operand[7], operand[7:1]};
        carryOut = operand[0];
      end
      default: begin
        result   = operand;
        carryOut = carryIn;
      end
    endcase
  end

endmodule // shift_rotate_unit

`default_nettype wire

// >>> verification/bit_shift_flag_instr_exec_test.sv
`timescale 1ns/1ns
`include "bit_exec_consts.svh"
`default_nettype none

module bit_shift_flag_instr_exec_test;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       instrValid = 1'b0;
  logic [4:0] instrOp = 5'h00;
  logic [4:0] regAddr = 5'h00;
  logic [2:0] bitSel = 3'h0;
  logic [4:0] ioAddrIn = 5'h00;
  logic [7:0] immData = 8'h00;
  logic [7:0] stackPopData = 8'h00;
  logic [7:0] ioReadData = 8'h00;
  logic       debugResume = 1'b0;
  logic       instrReady, instrDone, stackPush, stackPop, ioRead, ioWrite, breakHalt, regWbValid;
  logic [7:0] stackPushData, ioWriteData, statusFlags, regWbData;
  logic [4:0] ioAddr, regWbAddr;
  int         n_errors = 0;
  int         checks = 0;
  // captured per operation
  logic       gotPush, gotPop, gotRd, gotWr, wbV;
  logic [7:0] gotPushData, gotWrData, wbD, flagsSeen, expFlags;
  logic [4:0] gotRdAddr, wbA;

  bit_shift_flag_instr_exec #(.REG_COUNT(32)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .instrValid(instrValid), .instrOp(instrOp), .regAddr(regAddr),
    .bitSel(bitSel), .ioAddrIn(ioAddrIn), .immData(immData), .instrReady(instrReady),
    .instrDone(instrDone), .stackPush(stackPush), .stackPushData(stackPushData), .stackPop(stackPop),
    .stackPopData(stackPopData), .ioRead(ioRead), .ioWrite(ioWrite), .ioAddr(ioAddr),
    .ioReadData(ioReadData), .ioWriteData(ioWriteData), .breakHalt(breakHalt),
    .debugResume(debugResume), .statusFlags(statusFlags), .regWbValid(regWbValid),
    .regWbAddr(regWbAddr), .regWbData(regWbData));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] expv, input logic [7:0] got);
    checks++;
    if (got !== expv) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, expv, got);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d, checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // issue one op, count cycles to done, capture strobes and the writeback that follows
  task automatic do_op(input bit_exec_pkg::op_t op, input logic [4:0] ra, input logic [2:0] bs,
                       input logic [7:0] imm, input int cyc);
    int n;
    n = 0;
    @(negedge ref_clk);
    instrOp = op; regAddr = ra; bitSel = bs; ioAddrIn = ra; immData = imm; instrValid = 1'b1;
    {gotPush, gotPop, gotRd, gotWr} = 4'h0;
    #1;
    while (instrReady !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      #1;
      n++;
    end
    @(negedge ref_clk);
    instrValid = 1'b0;
    n = 1;
    forever begin
      #1;
      if (stackPush === 1'b1) begin gotPush = 1'b1; gotPushData = stackPushData; end
      if (stackPop === 1'b1) gotPop = 1'b1;
      if (ioRead === 1'b1) begin gotRd = 1'b1; gotRdAddr = ioAddr; end
      if (ioWrite === 1'b1) begin gotWr = 1'b1; gotWrData = ioWriteData; end
      if (instrDone === 1'b1 || n >= 20) break;
      @(negedge ref_clk);
      n++;
    end
    chk("cycles", 8'(cyc), 8'(n));
    @(negedge ref_clk);
    #1;
    wbV = regWbValid; wbA = regWbAddr; wbD = regWbData; flagsSeen = statusFlags;
  endtask

  function automatic logic [8:0] shRef(input bit_exec_pkg::op_t op, input logic [7:0] v, input logic c);
    case (op)
      bit_exec_pkg::logic_shift_left_op:   return {v[7], v[6:0], 1'b0};
      bit_exec_pkg::logic_shift_right_op:  return {v[0], 1'b0, v[7:1]};
      bit_exec_pkg::rotate_left_carry_op:  return {v[7], v[6:0], c};
      bit_exec_pkg::rotate_right_carry_op: return {v[0], c, v[7:1]};
      default:                             return {v[0], v[7], v[7:1]};
    endcase
  endfunction

  function automatic logic [7:0] shFlags(input logic [7:0] f, input logic [7:0] r, input logic c);
    f[`FLAG_CARRY] = c;
    f[`FLAG_ZERO] = (r == 8'h00);
    f[`FLAG_NEG] = r[7];
    f[`FLAG_OVF] = r[7] ^ c;
    f[`FLAG_SIGN] = c;
    return f;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("flags after reset", `FLAGS_RESET, statusFlags);
    chk("ready halt wb", 8'h04, {5'h00, instrReady, breakHalt, regWbValid});
  endtask

  task automatic t_shifts();
    bit_exec_pkg::op_t ops[6];
    logic [8:0] r;
    logic [7:0] v;
    ops = '{bit_exec_pkg::logic_shift_left_op, bit_exec_pkg::rotate_left_carry_op,
            bit_exec_pkg::rotate_right_carry_op, bit_exec_pkg::logic_shift_right_op,
            bit_exec_pkg::rotate_right_carry_op, bit_exec_pkg::arith_shift_right_op};
    do_op(bit_exec_pkg::reg_load_op, 5'h04, 3'h0, 8'h00, 1);
    do_op(bit_exec_pkg::reg_load_op, 5'h03, 3'h0, 8'h81, 1);
    // every flag set then cleared, so the model starts from a known state
    for (int s = 0; s < 8; s++) begin
      do_op(bit_exec_pkg::flag_set_op, 5'h00, 3'(s), 8'h00, 1);
      chk("flag set", 8'h01 << s, flagsSeen);
      do_op(bit_exec_pkg::flag_clear_op, 5'h00, 3'(s), 8'h00, 1);
      chk("flag clear", 8'h00, flagsSeen);
    end
    expFlags = 8'h00;
    v = 8'h81;
    foreach (ops[i]) begin
      do_op(ops[i], 5'h03, 3'h0, 8'h00, 1);
      r = shRef(ops[i], v, expFlags[`FLAG_CARRY]);
      v = r[7:0];
      expFlags = shFlags(expFlags, r[7:0], r[8]);
      chk("shift result", v, wbD);
      chk("shift wb", 8'h23, {2'h0, wbV, wbA});
      chk("shift flags", expFlags, flagsSeen);
    end
  endtask

  task automatic t_swap_nop();
    // the shift chain leaves zero behind, so give the swap a lopsided value
    do_op(bit_exec_pkg::reg_load_op, 5'h03, 3'h0, 8'hc0, 1);
    do_op(bit_exec_pkg::nibble_swap_op, 5'h03, 3'h0, 8'h00, 1);
    chk("swap result", 8'h0c, wbD);
    chk("swap flags", expFlags, flagsSeen);
    do_op(bit_exec_pkg::nop_op, 5'h03, 3'h0, 8'h00, 1);
    chk("nop wb", 8'h00, {7'h00, wbV});
    chk("nop flags", expFlags, flagsSeen);
  endtask

  task automatic t_bits();
    do_op(bit_exec_pkg::bit_to_transfer_flag_op, 5'h03, 3'h3, 8'h00, 1);
    expFlags[`FLAG_XFER] = 1'b1;
    chk("store bit one", expFlags, flagsSeen);
    do_op(bit_exec_pkg::transfer_flag_to_bit_op, 5'h04, 3'h5, 8'h00, 1);
    chk("load bit", 8'h20, wbD);
    chk("load bit flags", expFlags, flagsSeen);
    do_op(bit_exec_pkg::bit_to_transfer_flag_op, 5'h03, 3'h0, 8'h00, 1);
    expFlags[`FLAG_XFER] = 1'b0;
    chk("store bit zero", expFlags, flagsSeen);
  endtask

  task automatic t_flag_ops();
    do_op(bit_exec_pkg::overflow_flag_set_op, 5'h00, 3'h0, 8'h00, 1);
    chk("ovf set", expFlags | 8'h08, flagsSeen);
    do_op(bit_exec_pkg::half_carry_set_op, 5'h00, 3'h0, 8'h00, 1);
    chk("half set", expFlags | 8'h28, flagsSeen);
    do_op(bit_exec_pkg::overflow_flag_clear_op, 5'h00, 3'h0, 8'h00, 1);
    chk("ovf clear", (expFlags | 8'h20) & 8'hf7, flagsSeen);
    do_op(bit_exec_pkg::half_carry_clear_op, 5'h00, 3'h0, 8'h00, 1);
    expFlags = expFlags & 8'hd7;
    chk("half clear", expFlags, flagsSeen);
  endtask

  task automatic t_stack_io();
    do_op(bit_exec_pkg::push_op, 5'h03, 3'h0, 8'h00, 2);
    chk("push strobe data", 8'h8c, {gotPush, gotPushData[6:0]});
    chk("push flags", expFlags, flagsSeen);
    stackPopData = 8'ha5;
    do_op(bit_exec_pkg::pop_op, 5'h05, 3'h0, 8'h00, 2);
    chk("pop result", 8'ha5, wbD);
    chk("pop wb", 8'h65, {1'b0, gotPop, wbV, wbA});
    chk("pop flags", expFlags, flagsSeen);
    ioReadData = 8'h50;
    do_op(bit_exec_pkg::io_bit_set_op, 5'h09, 3'h1, 8'h00, 2);
    chk("io set read", 8'h29, {2'h0, gotRd, gotRdAddr});
    chk("io set write", 8'h52, gotWr ? gotWrData : 8'hxx);
    do_op(bit_exec_pkg::io_bit_clear_op, 5'h09, 3'h4, 8'h00, 2);
    chk("io clear write", 8'h40, gotWr ? gotWrData : 8'hxx);
    chk("io flags", expFlags, flagsSeen);
  endtask

  task automatic t_break();
    @(negedge ref_clk);
    instrOp = bit_exec_pkg::break_op;
    instrValid = 1'b1;
    @(negedge ref_clk);
    instrOp = bit_exec_pkg::nop_op;
    repeat (3) @(negedge ref_clk);
    #1;
    chk("halted", 8'h02, {6'h00, breakHalt, instrReady});
    instrValid = 1'b0;
    debugResume = 1'b1;
    #1;
    chk("resume done", 8'h01, {7'h00, instrDone});
    @(negedge ref_clk);
    debugResume = 1'b0;
    #1;
    chk("resumed", 8'h01, {6'h00, breakHalt, instrReady});
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge ref_clk);
    #1;
    t_reset();
    rst_n = 1'b1;
    t_shifts();
    t_swap_nop();
    t_bits();
    t_flag_ops();
    t_stack_io();
    t_break();
    stop_test();
  end

  initial begin
    #(100 * 5000);
    n_errors++;
    stop_test();
  end
endmodule // bit_shift_flag_instr_exec_test

`default_nettype wire
